// *** i2c_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****
// Bus master driving the clock and the open-drain data line.
// ****
module i2c_host_model (
  // Clock.
  input wire logic core_clk,
  // Bus.
  input wire logic sdaWire,
  output logic scl,
  output logic sdaLow
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic start();
    sdaLow <= 1'b0;
    hold(5);
    scl <= 1'b1;
    hold(10);
    sdaLow <= 1'b1;
    hold(10);
    scl <= 1'b0;
    hold(5);
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    hold(5);
    scl <= 1'b1;
    hold(10);
    sdaLow <= 1'b0;
    hold(10);
  endtask
  // Nine bits, high bit first; bit 0 is the acknowledge slot.
  task automatic xfer(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      sdaLow <= !o[k];
      hold(5);
      scl <= 1'b1;
      hold(5);
      i[k] = sdaWire;
      hold(5);
      scl <= 1'b0;
      hold(5);
    end
  endtask
endmodule // i2c_host_model
`default_nettype wire

// *** light_sensor_register_bank.v ***
`timescale 1ns/10ps
`default_nettype none
`include "light_sensor_regs.vh"
module light_sensor_register_bank #(
  parameter [6:0] DEV_ADDR = 7'h44,
  parameter [15:0] MAKER_CODE_BITS = 16'h1234,
  parameter [15:0] PART_CODE_BITS = 16'h5678,
  parameter [26:0] CONV_SHORT_CYC = `CONV_SHORT_CYC,
  parameter [26:0] CONV_LONG_CYC = `CONV_LONG_CYC
) (
  // Clock, reset and enable.
  input wire core_clk,
  input wire sys_rst,
  input wire clkEn,
  // Serial bus pins.
  input wire sclIn,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe,
  // Light front end, in 0.01 lux units.
  input wire [22:0] lightCount,
  // Status.
  output reg converting_reg
);

  // MAKER_CODE_BITS and PART_CODE_BITS defaults are arbitrary values.

  reg sclS1;
  reg sclS2;
  reg sdaS1;
  reg sdaS2;
  reg [22:0] lightS1;
  reg [22:0] lightS2;
  reg [7:0] ptr_reg;
  reg [15:0] rdWord_reg;
  reg [3:0] rangeSel_reg;
  reg convTimeSel_reg;
  reg [1:0] mode_reg;
  reg overflowFlag_reg;
  reg convReadyFlag_reg;
  reg highFlag_reg;
  reg lowFlag_reg;
  reg latch_reg;
  reg polarity_reg;
  reg exponentMask_reg;
  reg [1:0] faultCount_reg;
  reg [15:0] lowerThr_reg;
  reg [15:0] upperThr_reg;
  reg [3:0] resultExp_reg;
  reg [11:0] resultMant_reg;
  reg [26:0] timer_reg;
  wire ptrWr;
  wire [7:0] ptrData;
  wire wrStb;
  wire [15:0] wrData;
  wire rdDone;
  wire [15:0] controlWord;
  wire [26:0] convLimit;
  wire convDone;
  reg [3:0] expNext;
  reg [11:0] mantNext;
  reg ovfNext;
  reg found;
  reg [22:0] shifted;
  reg [3:0] reportExp;
  reg [26:0] resLin;
  reg [26:0] lowLin;
  reg [26:0] upLin;
  integer i;
  localparam [15:0] CTL_INIT = `CTL_RESET;

  assign sdaOut = 1'b0;

  // ****************************************
  // Pin synchronisers.
  // ****************************************
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclS1 <= 1'b1;
      sclS2 <= 1'b1;
      sdaS1 <= 1'b1;
      sdaS2 <= 1'b1;
      lightS1 <= 23'h000000;
      lightS2 <= 23'h000000;
    end else if (clkEn) begin
      sclS1 <= sclIn;
      sclS2 <= sclS1;
      sdaS1 <= sdaIn;
      sdaS2 <= sdaS1;
      lightS1 <= lightCount;
      lightS2 <= lightS1;
    end
  end

  serial_reg_port #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .sclSync(sclS2),
    .sdaSync(sdaS2),
    .sdaOe(sdaOe),
    .rdWord(rdWord_reg),
    .ptrWr(ptrWr),
    .ptrData(ptrData),
    .wrStb(wrStb),
    .wrData(wrData),
    .rdDone(rdDone)
  );

  // ****************************************
  // Range selection and result coding.
  // ****************************************
  always @* begin
    expNext = `RANGE_MAX;
    mantNext = `MANT_FULL;
    ovfNext = 1'b1;
    found = 1'b0;
    shifted = 23'h000000;
    if (rangeSel_reg >= `RANGE_AUTO) begin
      for (i = 0; i <= 11; i = i + 1) begin
        shifted = lightS2 >> i;
        if (!found && shifted <= {11'h000, `MANT_FULL}) begin
          found = 1'b1;
          expNext = i[3:0]; // RL7
          mantNext = shifted[11:0]; // RL6
          ovfNext = 1'b0;
        end
      end
    end else begin
      shifted = lightS2 >> rangeSel_reg;
      expNext = rangeSel_reg; // RL7
      if (shifted <= {11'h000, `MANT_FULL}) begin
        mantNext = shifted[11:0]; // RL6
        ovfNext = 1'b0;
      end
    end
    if (exponentMask_reg && rangeSel_reg < `RANGE_AUTO) begin
      reportExp = 4'h0; // RL8
    end else begin
      reportExp = expNext;
    end
    resLin = {15'h0000, mantNext} << expNext;
    lowLin = {15'h0000, lowerThr_reg[11:0]} << lowerThr_reg[15:12];
    upLin = {15'h0000, upperThr_reg[11:0]} << upperThr_reg[15:12];
  end

  assign convLimit = convTimeSel_reg ? CONV_LONG_CYC : CONV_SHORT_CYC;
  assign convDone = converting_reg && (timer_reg == convLimit - 27'd1);

  assign controlWord = {rangeSel_reg, convTimeSel_reg, mode_reg, overflowFlag_reg, convReadyFlag_reg, // RL12
                        highFlag_reg, lowFlag_reg, latch_reg, polarity_reg, exponentMask_reg, faultCount_reg};

  // ****************************************
  // Registers and conversion sequencing.
  // ****************************************
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_reg <= `PTR_RESULT;
      rdWord_reg <= 16'h0000;
      rangeSel_reg <= CTL_INIT[`CTL_RANGE_HI:`CTL_RANGE_LO]; // RL11
      convTimeSel_reg <= CTL_INIT[`CTL_CTIME];
      mode_reg <= CTL_INIT[`CTL_MODE_HI:`CTL_MODE_LO];
      overflowFlag_reg <= 1'b0;
      convReadyFlag_reg <= 1'b0;
      highFlag_reg <= 1'b0;
      lowFlag_reg <= 1'b0;
      latch_reg <= CTL_INIT[`CTL_LATCH];
      polarity_reg <= 1'b0;
      exponentMask_reg <= 1'b0;
      faultCount_reg <= 2'h0;
      lowerThr_reg <= 16'h0000;
      upperThr_reg <= 16'hffff;
      resultExp_reg <= 4'h0;
      resultMant_reg <= 12'h000;
      timer_reg <= 27'd0;
      converting_reg <= 1'b0;
    end else if (clkEn) begin
      if (ptrWr) begin
        ptr_reg <= ptrData; // RL15
      end
      if (wrStb && ptr_reg == `PTR_CONTROL) begin
        rangeSel_reg <= wrData[`CTL_RANGE_HI:`CTL_RANGE_LO];
        convTimeSel_reg <= wrData[`CTL_CTIME];
        mode_reg <= wrData[`CTL_MODE_HI:`CTL_MODE_LO];
        latch_reg <= wrData[`CTL_LATCH];
        polarity_reg <= wrData[`CTL_POL];
        exponentMask_reg <= wrData[`CTL_EMASK];
        faultCount_reg <= wrData[`CTL_FC_HI:`CTL_FC_LO];
        timer_reg <= 27'd0; // RL9
        converting_reg <= (wrData[`CTL_MODE_HI:`CTL_MODE_LO] != `MODE_OFF); // RL10
      end else if (convDone) begin
        resultExp_reg <= reportExp; // RL4
        resultMant_reg <= mantNext;
        overflowFlag_reg <= ovfNext;
        timer_reg <= 27'd0;
        if (mode_reg == `MODE_SINGLE) begin
          mode_reg <= `MODE_OFF;
          converting_reg <= 1'b0;
        end
      end else if (converting_reg) begin
        timer_reg <= timer_reg + 27'd1;
      end
      if (wrStb && ptr_reg == `PTR_LOWER) begin
        lowerThr_reg <= wrData; // RL13
      end
      if (wrStb && ptr_reg == `PTR_UPPER) begin
        upperThr_reg <= wrData; // RL13
      end
      if (convDone) begin
        convReadyFlag_reg <= 1'b1;
      end else if (rdDone && ptr_reg == `PTR_CONTROL) begin
        convReadyFlag_reg <= 1'b0; // RL16
      end
      if (convDone && !latch_reg) begin
        highFlag_reg <= resLin > upLin;
        lowFlag_reg <= resLin < lowLin;
      end else if (convDone) begin
        highFlag_reg <= highFlag_reg | (resLin > upLin);
        lowFlag_reg <= lowFlag_reg | (resLin < lowLin);
      end else if (rdDone && ptr_reg == `PTR_CONTROL && latch_reg) begin
        highFlag_reg <= 1'b0;
        lowFlag_reg <= 1'b0;
      end
      case (ptr_reg)
        `PTR_RESULT: rdWord_reg <= {resultExp_reg, resultMant_reg}; // RL5
        `PTR_CONTROL: rdWord_reg <= controlWord; // RL2
        `PTR_LOWER: rdWord_reg <= lowerThr_reg;
        `PTR_UPPER: rdWord_reg <= upperThr_reg;
        `PTR_MAKER: rdWord_reg <= MAKER_CODE_BITS; // RL3
        `PTR_PART: rdWord_reg <= PART_CODE_BITS; // RL3
        default: rdWord_reg <= 16'h0000; // RL1
      endcase
    end
  end

endmodule // light_sensor_register_bank
`default_nettype wire

// *** light_sensor_register_bank_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****
// Bus and conversion checks.
// ****
module light_sensor_checker #(
  parameter logic [26:0] CONV_SHORT_CYC = 27'd200,
  parameter logic [26:0] CONV_LONG_CYC = 27'd400
) (
  input wire core_clk,
  input wire sys_rst,
  input wire clkEn,
  input wire sclIn,
  input wire sdaIn,
  input wire sdaOut,
  input wire sdaOe,
  input wire [22:0] lightCount,
  input wire converting_reg
);
  logic sclPrev;
  logic [3:0] sclCnt;
  logic [5:0] ackAge;
  logic [26:0] runCnt;
  logic [26:0] convCnt;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclPrev <= 1'b1;
      sclCnt <= 4'h0;
      ackAge <= 6'h3f;
      runCnt <= 27'h0;
      convCnt <= 27'h0;
    end else begin
      sclPrev <= sclIn;
      sclCnt <= sdaOe ? sclCnt + {3'h0, sclIn && !sclPrev} : 4'h0;
      ackAge <= sdaOe ? 6'h0 : ackAge + {5'h0, ackAge != 6'h3f};
      runCnt <= converting_reg ? runCnt + 27'h1 : 27'h0;
      convCnt <= (converting_reg && !sdaOe) ? convCnt + 27'h1 : 27'h0;
    end
  end
  sda_low_only_a:
    assert property (sdaOut == 1'b0) else $error("data output not low");
  sda_change_low_a:
    assert property ($changed(sdaOe) |-> !sclIn && !$past(sclIn)) else $error("data moved in clock high");
  byte_len_a:
    assert property (sclCnt <= 4'd9) else $error("device drove too many bits");
  conv_start_a:
    assert property ($rose(converting_reg) |-> ackAge < 6'd40) else $error("conversion began without write");
  conv_len_a:
    assert property ($fell(converting_reg) && ackAge > 6'd40 |-> runCnt >= CONV_SHORT_CYC - 27'd16)
      else $error("conversion ended early");
  conv_bound_a:
    assert property (convCnt <= CONV_LONG_CYC + 27'd2) else $error("conversion never completed");
  start_quiet_a:
    assert property (sclIn && $fell(sdaIn) && !sdaOe |=> !sdaOe [*8]) else $error("driven after start");
  reset_quiet_a:
    assert property ($fell(sys_rst) |-> !sdaOe [*3]) else $error("driven after reset");
  cover property ($rose(converting_reg));
  cover property ($fell(converting_reg) && ackAge < 6'd40);
  cover property (sclCnt == 4'd9);
endmodule // light_sensor_checker
bind light_sensor_register_bank light_sensor_checker #(
  .CONV_SHORT_CYC(CONV_SHORT_CYC),
  .CONV_LONG_CYC(CONV_LONG_CYC)
) chk (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .clkEn(clkEn),
  .sclIn(sclIn),
  .sdaIn(sdaIn),
  .sdaOut(sdaOut),
  .sdaOe(sdaOe),
  .lightCount(lightCount),
  .converting_reg(converting_reg)
);
`default_nettype wire

// *** light_sensor_regs.vh ***
// Summary of operation
// RL1 - Every software-visible register is one 16-bit word.
// RL2 - Pointer 00h result, 01h configuration, 02h lower threshold, 03h upper threshold.
// RL3 - Read-only maker code at 7Eh and part code at 7Fh.
// RL4 - Result is read-only and holds the latest completed conversion.
// RL5 - Result exponent sits in bits 15:12, mantissa in bits 11:0.
// RL6 - Mantissa is unsigned straight binary from zero to range full scale.
// RL7 - Exponent codes 0 to 11 select binary-weighted ranges, step 0.01 lux times 2^e.
// RL8 - Exponent mask with manual range below 1100b reports exponent as zero.
// RL9 - A configuration write aborts any running conversion at once.
// RL10 - After a configuration write, start a new conversion if the mode asks for one.
// RL11 - Configuration resets to C810h.
// RL12 - Configuration holds eleven fields; bits 8 to 5 are read-only.
// RL13 - Threshold registers share the result layout and are read-write.
// RL14 - Pointer byte follows the write address byte; data moves high byte first.
// RL15 - The pointer is kept so repeated reads return the same register.
// RL16 - Reading configuration clears the conversion-ready flag right after the read.
`ifndef LIGHT_SENSOR_REGS_VH
`define LIGHT_SENSOR_REGS_VH

// ****************************************
// Register pointers.
// ****************************************
`define PTR_RESULT 8'h00
`define PTR_CONTROL 8'h01
`define PTR_LOWER 8'h02
`define PTR_UPPER 8'h03
`define PTR_MAKER 8'h7e
`define PTR_PART 8'h7f

// ****************************************
// Configuration fields and reset value.
// ****************************************
`define CTL_RESET 16'hc810
`define CTL_RANGE_HI 15
`define CTL_RANGE_LO 12
`define CTL_CTIME 11
`define CTL_MODE_HI 10
`define CTL_MODE_LO 9
`define CTL_OVF 8
`define CTL_CRF 7
`define CTL_FH 6
`define CTL_FL 5
`define CTL_LATCH 4
`define CTL_POL 3
`define CTL_EMASK 2
`define CTL_FC_HI 1
`define CTL_FC_LO 0
`define RANGE_AUTO 4'hc
`define RANGE_MAX 4'hb
`define MODE_OFF 2'h0
`define MODE_SINGLE 2'h1
`define MANT_FULL 12'hfff

// ****************************************
// Timing.
// ****************************************
`define CLK_MHZ 125
`define CONV_SHORT_MS 100
`define CONV_LONG_MS 800
`define CONV_SHORT_CYC (`CONV_SHORT_MS * 1000 * `CLK_MHZ)
`define CONV_LONG_CYC (`CONV_LONG_MS * 1000 * `CLK_MHZ)

`endif

// *** serial_reg_port.v ***
`timescale 1ns/10ps
`default_nettype none
module serial_reg_port #(
  parameter [6:0] DEV_ADDR = 7'h44
) (
  // Clock and reset.
  input wire core_clk,
  input wire sys_rst,
  input wire clkEn,
  // Bus pins, already synchronised.
  input wire sclSync,
  input wire sdaSync,
  output reg sdaOe,
  // Register side.
  input wire [15:0] rdWord,
  output reg ptrWr,
  output reg [7:0] ptrData,
  output reg wrStb,
  output reg [15:0] wrData,
  output reg rdDone
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_ACK = 3'd2;
  localparam [2:0] ST_RX = 3'd3;
  localparam [2:0] ST_TX = 3'd4;
  localparam [2:0] ST_TACK = 3'd5;
  localparam [2:0] ST_TXGO = 3'd6;

  reg sclDly;
  reg sdaDly;
  reg [2:0] st;
  reg [3:0] bitCnt;
  reg [7:0] shReg;
  reg [7:0] msbHold;
  reg [15:0] txWord;
  reg [1:0] byteCnt;
  reg rw;
  wire sclRise = sclSync & ~sclDly;
  wire sclFall = ~sclSync & sclDly;
  wire startCond = sclSync & sclDly & sdaDly & ~sdaSync;
  wire stopCond = sclSync & sclDly & ~sdaDly & sdaSync;

  // ****************************************
  // Byte engine.
  // ****************************************
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclDly <= 1'b1;
      sdaDly <= 1'b1;
      st <= ST_IDLE;
      bitCnt <= 4'h0;
      shReg <= 8'h00;
      msbHold <= 8'h00;
      txWord <= 16'h0000;
      byteCnt <= 2'h0;
      rw <= 1'b0;
      sdaOe <= 1'b0;
      ptrWr <= 1'b0;
      ptrData <= 8'h00;
      wrStb <= 1'b0;
      wrData <= 16'h0000;
      rdDone <= 1'b0;
    end else if (clkEn) begin
      sclDly <= sclSync;
      sdaDly <= sdaSync;
      ptrWr <= 1'b0;
      wrStb <= 1'b0;
      rdDone <= 1'b0;
      if (startCond) begin
        st <= ST_ADDR;
        bitCnt <= 4'h0;
        byteCnt <= 2'h0;
        sdaOe <= 1'b0;
      end else if (stopCond) begin
        st <= ST_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (st)
          ST_ADDR, ST_RX: begin
            if (sclRise && bitCnt != 4'h8) begin
              shReg <= {shReg[6:0], sdaSync};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == 4'h8) begin
              bitCnt <= 4'h0;
              if (st == ST_ADDR) begin
                if (shReg[7:1] == DEV_ADDR) begin
                  sdaOe <= 1'b1;
                  rw <= shReg[0];
                  txWord <= rdWord;
                  st <= ST_ACK;
                end else begin
                  st <= ST_IDLE;
                end
              end else begin
                sdaOe <= 1'b1;
                st <= ST_ACK;
                if (byteCnt == 2'h0) begin
                  ptrWr <= 1'b1; // RL14
                  ptrData <= shReg;
                end else if (byteCnt == 2'h1) begin
                  msbHold <= shReg; // RL14
                end else begin
                  wrStb <= 1'b1;
                  wrData <= {msbHold, shReg};
                end
                byteCnt <= (byteCnt == 2'h2) ? 2'h1 : byteCnt + 2'h1;
              end
            end
          end
          ST_ACK, ST_TXGO: begin
            if (sclFall) begin
              if (rw) begin
                sdaOe <= ~txWord[15]; // RL14
                txWord <= {txWord[14:0], 1'b0};
                bitCnt <= 4'h1;
                st <= ST_TX;
              end else begin
                sdaOe <= 1'b0;
                st <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (sclFall) begin
              if (bitCnt == 4'h8) begin
                sdaOe <= 1'b0;
                st <= ST_TACK;
              end else begin
                sdaOe <= ~txWord[15];
                txWord <= {txWord[14:0], 1'b0};
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          ST_TACK: begin
            if (sclRise) begin
              byteCnt <= {1'b0, ~byteCnt[0]};
              if (byteCnt[0]) begin
                rdDone <= 1'b1;
                txWord <= rdWord;
              end
              st <= sdaSync ? ST_IDLE : ST_TXGO;
            end
          end
          default: begin
            st <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // serial_reg_port
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****
// Register bank testbench.
// ****
module tb_top;
  localparam logic [15:0] MAKER = 16'h0a5c; // Arbitrary value.
  localparam logic [15:0] PART = 16'h3c96; // Arbitrary value.
  localparam logic [6:0] DEV = 7'h44;
  logic core_clk, sys_rst, clkEn;
  logic [22:0] light;
  wire scl, sdaLow, sdaOe, sdaOut, converting;
  wire sdaWire = !(sdaLow || sdaOe);
  int nMismatch, checks;
  light_sensor_register_bank #(.MAKER_CODE_BITS(MAKER), .PART_CODE_BITS(PART), .CONV_SHORT_CYC(27'd200),
    .CONV_LONG_CYC(27'd2000)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .sclIn(scl),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .lightCount(light), .converting_reg(converting));
  i2c_host_model host (.core_clk(core_clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = !core_clk;
  end
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic summarize();
    if (nMismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    logic [8:0] r;
    host.start();
    host.xfer({DEV, 2'b01}, r);
    host.xfer({p, 1'b1}, r);
    host.xfer({d[15:8], 1'b1}, r);
    host.xfer({d[7:0], 1'b1}, r);
    host.stop();
  endtask
  task automatic rc(input string w, input logic [7:0] p, input logic s, input logic [15:0] m, e);
    logic [8:0] r;
    logic [15:0] d;
    if (s) begin
      host.start();
      host.xfer({DEV, 2'b01}, r);
      host.xfer({p, 1'b1}, r);
    end
    host.start();
    host.xfer({DEV, 2'b11}, r);
    host.xfer(9'h1fe, r);
    d[15:8] = r[8:1];
    host.xfer(9'h1ff, r);
    d[7:0] = r[8:1];
    host.stop();
    chk(w, e, d & m);
  endtask
  task automatic t_reset();
    rc("ctl", 8'h01, 1, 16'hffff, 16'hc810);
    rc("lo", 8'h02, 1, 16'hffff, 16'h0000);
    rc("hi", 8'h03, 1, 16'hffff, 16'hffff);
    rc("res", 8'h00, 1, 16'hffff, 16'h0000);
    wr(8'h7e, 16'h0000);
    rc("maker", 8'h7e, 1, 16'hffff, MAKER);
    rc("part", 8'h7f, 1, 16'hffff, PART);
    rc("gap", 8'h10, 1, 16'hffff, 16'h0000);
  endtask
  task automatic t_regs();
    wr(8'h02, 16'h1abc);
    wr(8'h03, 16'hb123);
    rc("lo", 8'h02, 1, 16'hffff, 16'h1abc);
    rc("hi", 8'h03, 1, 16'hffff, 16'hb123);
    rc("hi again", 8'h00, 0, 16'hffff, 16'hb123);
    wr(8'h01, 16'h01ff);
    rc("ctl", 8'h01, 1, 16'hffff, 16'h001f);
  endtask
  task automatic t_conv();
    logic [15:0] cfg [3] = '{16'h0210, 16'hc210, 16'h5214};
    logic [22:0] lux [3] = '{23'd1000, 23'd100000, 23'd100000};
    logic [15:0] res [3] = '{16'h03e8, 16'h5c35, 16'h0c35};
    logic [15:0] flg [3] = '{16'h0020, 16'h0000, 16'h0000};
    for (int k = 0; k < 3; k++) begin
      light <= lux[k];
      wr(8'h01, cfg[k]);
      chk("conv", 16'h0001, {15'h0, converting});
      for (int n = 0; n < 3000 && converting !== 1'b0; n++)
        @(posedge core_clk);
      rc("res", 8'h00, 1, 16'hffff, res[k]);
      rc("ctl", 8'h01, 1, 16'hffff, (cfg[k] & 16'hf91f) | 16'h0080 | flg[k]);
      rc("ctl again", 8'h01, 0, 16'hffff, cfg[k] & 16'hf91f);
    end
    wr(8'h00, 16'h1234);
    rc("res", 8'h00, 1, 16'hffff, 16'h0c35);
  endtask
  task automatic t_abort();
    logic [8:0] r;
    wr(8'h01, 16'h0a10);
    chk("conv", 16'h0001, {15'h0, converting});
    wr(8'h01, 16'h0010);
    chk("conv", 16'h0000, {15'h0, converting});
    rc("ctl", 8'h01, 1, 16'hff9f, 16'h0010);
    rc("res", 8'h00, 1, 16'hffff, 16'h0c35);
    host.start();
    host.xfer({7'h45, 2'b01}, r);
    host.stop();
    chk("nack", 16'h0001, {15'h0, r[0]});
  endtask
  initial begin
    nMismatch = 0;
    checks = 0;
    sys_rst = 1'b1;
    clkEn = 1'b1;
    light = 23'd0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    t_reset();
    t_regs();
    t_conv();
    t_abort();
    summarize();
  end
  initial begin
    repeat (70000) @(posedge core_clk);
    nMismatch++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
